// file: sfef_frame_check.v
`timescale 1ns/1ps
`default_nettype none
`include "sfef_defs.vh"
module sfef_frame_check
(
    // Clock and reset
    input wire core_clk,
    input wire rst,
    // Serial pins
    input wire sclk,
    input wire cs_n,
    input wire mosi,
    output reg miso,
    output reg miso_oe,
    // Configuration
    input wire extended_packet_select,
    input wire [4:0] packet_len,
    input wire crc_check_en,
    // Other warning sources and clearing
    input wire [8:0] other_warnings,
    input wire flag_clear,
    input wire crc_bad,
    // Status
    output reg frame_error_flag,
    output reg crc_error_flag
);

// ==========================================
// Synchronisers
reg [1:0] sclk_s;
reg [1:0] cs_s;
reg [1:0] mosi_s;
reg sclk_d;
reg cs_d;
always @(posedge core_clk)
begin
    if (rst)
    begin
        sclk_s <= 2'h3;
        cs_s <= 2'h3;
        mosi_s <= 2'h0;
        sclk_d <= 1'b1;
        cs_d <= 1'b1;
    end
    else
    begin
        sclk_s <= {sclk_s[0], sclk};
        cs_s <= {cs_s[0], cs_n};
        mosi_s <= {mosi_s[0], mosi};
        sclk_d <= sclk_s[1];
        cs_d <= cs_s[1];
    end
end

wire sclk_fall = sclk_d & ~sclk_s[1];
wire sclk_rise = ~sclk_d & sclk_s[1];
wire cs_start = cs_d & ~cs_s[1];
wire cs_end = ~cs_d & cs_s[1];
wire selected = ~cs_s[1];

// ==========================================
// Edge counting
reg [5:0] fall_cnt;
reg [5:0] stray_cnt;
reg [4:0] since_rise;
reg stray_early;
reg first_bit;
reg sync_bad;
reg [15:0] shift_in;
reg [5:0] addr;
reg rw;
reg [5:0] next_addr;
reg next_rw;
reg keep_frame;
reg [15:0] shift_out;
reg [15:0] next_shift_out;
reg next_frame_error;
reg next_crc_error;

wire is21 = (packet_len == `SFEF_LEN_21);
// Deselected edges fold into the next frame count, except at length 21
wire [5:0] total = fall_cnt + stray_cnt;
wire len_bad = (total != {1'b0, packet_len});
wire stray_hit = !selected && sclk_fall && !is21;

function stray_fault;
    input [4:0] len;
    input ext;
    input [5:0] n;
    begin
        if (len == `SFEF_LEN_16 && !ext)
            stray_fault = (n >= 6'h01);
        else if (len == `SFEF_LEN_16)
            stray_fault = (n >= 6'h02);
        else if (len == `SFEF_LEN_17)
            stray_fault = (n >= 6'h01);
        else
            stray_fault = 1'b0;
    end
endfunction

// Writes and unknown addresses read as zero
function [15:0] read_word;
    input rd_rw;
    input [5:0] rd_addr;
    input [15:0] warn;
    begin
        if (rd_rw)
            read_word = 16'h0000;
        else if (rd_addr == `SFEF_WARN_ADDR_HI)
            read_word = warn;
        else if (rd_addr == `SFEF_WARN_ADDR_LO)
            read_word = {warn[7:0], 8'h00};
        else
            read_word = 16'h0000;
    end
endfunction

wire frame_bad = len_bad | sync_bad | stray_fault(packet_len, extended_packet_select, stray_cnt);

// ==========================================
// Deselect window timer
// Only the first cycles after deselect matter, so it saturates
always @(posedge core_clk)
begin
    if (rst)
    begin
        since_rise <= 5'h00;
    end
    else if (cs_end)
    begin
        since_rise <= 5'h00;
    end
    else if (since_rise != 5'h1F)
    begin
        since_rise <= since_rise + 5'h01;
    end
end

// ==========================================
// Sync bit and shift register
always @(posedge core_clk)
begin
    if (rst)
    begin
        first_bit <= 1'b0;
        sync_bad <= 1'b0;
        shift_in <= 16'h0000;
    end
    else if (cs_start)
    begin
        first_bit <= 1'b1;
        sync_bad <= 1'b0;
    end
    else if (selected && sclk_rise)
    begin
        // Sample on rising edge, first bit is sync
        if (first_bit)
            sync_bad <= mosi_s[1];
        first_bit <= 1'b0;
        shift_in <= {shift_in[14:0], mosi_s[1]};
    end
end

// ==========================================
// Clock edge counters
always @(posedge core_clk)
begin
    if (rst)
    begin
        fall_cnt <= 6'h00;
    end
    else if (cs_start)
    begin
        fall_cnt <= 6'h00;
    end
    else if (selected && sclk_fall)
    begin
        fall_cnt <= fall_cnt + 6'h01;
    end
end

// Stray edges survive until the next frame end, where they are judged
always @(posedge core_clk)
begin
    if (rst)
    begin
        stray_cnt <= 6'h00;
        stray_early <= 1'b0;
    end
    else if (cs_end)
    begin
        stray_cnt <= 6'h00;
        stray_early <= 1'b0;
    end
    else if (stray_hit && stray_cnt != 6'h3F)
    begin
        stray_cnt <= stray_cnt + 6'h01;
        if (since_rise < `SFEF_STRAY_WIN_CYC)
            stray_early <= 1'b1;
    end
end

// ==========================================
// Request decode
// An early stray edge on a bad frame keeps the previous request
always @*
begin
    keep_frame = !frame_bad || !stray_early;
    next_rw = rw;
    next_addr = addr;
    if (cs_end && keep_frame)
    begin
        next_rw = shift_in[14];
        next_addr = shift_in[13:8];
    end
end

always @(posedge core_clk)
begin
    if (rst)
    begin
        rw <= 1'b0;
        addr <= `SFEF_NOP_ADDR;
    end
    else
    begin
        rw <= next_rw;
        addr <= next_addr;
    end
end

// ==========================================
// Flags
wire [15:0] warn_word = {`SFEF_WARN_TOP, frame_error_flag, crc_error_flag, 1'b0, other_warnings};

always @*
begin
    next_frame_error = frame_error_flag;
    next_crc_error = crc_error_flag;
    // Set wins over clear; sticky otherwise
    if (cs_end && frame_bad)
        next_frame_error = 1'b1;
    else if (flag_clear)
        next_frame_error = 1'b0;
    if (cs_end && crc_check_en && (crc_bad || frame_bad))
        next_crc_error = 1'b1;
    else if (flag_clear)
        next_crc_error = 1'b0;
end

always @(posedge core_clk)
begin
    if (rst)
    begin
        frame_error_flag <= 1'b0;
        crc_error_flag <= 1'b0;
    end
    else
    begin
        frame_error_flag <= next_frame_error;
        crc_error_flag <= next_crc_error;
    end
end

// ==========================================
// Response shifter
always @*
begin
    next_shift_out = shift_out;
    if (cs_start)
        next_shift_out = read_word(rw, addr, warn_word);
    else if (selected && sclk_fall)
        next_shift_out = {shift_out[14:0], shift_out[15]};
end

always @(posedge core_clk)
begin
    if (rst)
    begin
        shift_out <= 16'h0000;
        miso <= 1'b0;
        miso_oe <= 1'b0;
    end
    else
    begin
        shift_out <= next_shift_out;
        miso_oe <= selected;
        if (selected && sclk_fall && !cs_start)
            miso <= shift_out[15];
    end
end

endmodule // sfef_frame_check
`default_nettype wire

// file: sfef_defs.vh
`ifndef SFEF_DEFS_VH
`define SFEF_DEFS_VH
// ==========================================
// Register map
`define SFEF_WARN_ADDR_HI 6'h26
`define SFEF_WARN_ADDR_LO 6'h27
`define SFEF_NOP_ADDR 6'h00
`define SFEF_BIT_FRAME_ERR 11
`define SFEF_BIT_CRC_ERR 10
`define SFEF_WARN_TOP 4'hB
// ==========================================
// Configuration
`define SFEF_CFG_ROW 6'h1B
`define SFEF_BIT_EXT_PKT 1
`define SFEF_EXT_PKT_RESET 1'b0
// ==========================================
// Packet lengths
`define SFEF_LEN_16 5'h10
`define SFEF_LEN_17 5'h11
`define SFEF_LEN_20 5'h14
`define SFEF_LEN_21 5'h15
// ==========================================
// Timing
`define SFEF_CLK_NS 40
`define SFEF_STRAY_WIN_NS 70
`define SFEF_STRAY_WIN_CYC ((`SFEF_STRAY_WIN_NS) / (`SFEF_CLK_NS))
`endif

// file: sfef_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
// Controller; link clock idles high, strays only on command
module sfef_ctrl_model(output var logic sclk, output var logic cs_n, output var logic mosi, input wire logic miso);
    logic [20:0] rx = 21'h000000;
    initial {sclk, cs_n, mosi} = 3'h7;
    task frame(input int n, input logic [20:0] w, input int s);
        cs_n = 0;
        #40;
        for (int i = n - 1; i >= 0; i--)
        begin
            sclk = 0;
            mosi = w[i];
            #160 rx = {rx[19:0], miso};
            sclk = 1;
            #160;
        end
        #40 cs_n = 1;
        mosi = ~mosi;
        #200;
        repeat (s)
        begin
            sclk = 0;
            #160 sclk = 1;
            #160;
        end
        #400;
    endtask
endmodule // sfef_ctrl_model
`default_nettype wire

// file: sfef_chk.sv
`timescale 1ns/1ps
`default_nettype none
module sfef_chk(input wire logic core_clk, rst, cs_n, miso_oe, flag_clear, crc_check_en, frame_error_flag,
    crc_error_flag);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    sequence s_sel; !cs_n [*4]; endsequence
    property p_oe; s_sel |-> miso_oe; endproperty
    property p_hold; frame_error_flag && !flag_clear |=> frame_error_flag; endproperty
    property p_set; $rose(frame_error_flag) |-> cs_n; endproperty
    property p_fall; $fell(frame_error_flag) |-> $past(flag_clear); endproperty
    property p_crch; crc_error_flag && !flag_clear |=> crc_error_flag; endproperty
    property p_crcen; $rose(crc_error_flag) |-> crc_check_en; endproperty
    a_oe: assert property (p_oe) else $error("miso_oe low while selected");
    a_hold: assert property (p_hold) else $error("frame flag dropped");
    a_set: assert property (p_set) else $error("frame flag set mid frame");
    a_fall: assert property (p_fall) else $error("frame flag fell unasked");
    a_crch: assert property (p_crch) else $error("crc flag dropped");
    a_crcen: assert property (p_crcen) else $error("crc flag while disabled");
endmodule // sfef_chk
bind sfef_frame_check sfef_chk u_chk(.core_clk(core_clk), .rst(rst), .cs_n(cs_n), .miso_oe(miso_oe),
    .flag_clear(flag_clear), .crc_check_en(crc_check_en), .frame_error_flag(frame_error_flag),
    .crc_error_flag(crc_error_flag));
`default_nettype wire

// file: spi_frame_error_flag_tb.sv
`timescale 1ns/1ps
`default_nettype none
module spi_frame_error_flag_tb;
    logic core_clk = 0, rst = 1, ext = 0, flag_clear = 0, cen = 0;
    logic [4:0] plen = 5'h10;
    logic [8:0] ow = 9'h000;
    logic [31:0] r = 32'h887EEAD4;
    logic [18:0] q[$];
    int miscompares = 0, samples_checked = 0;
    event ev;
    wire sclk, cs_n, mosi, miso, miso_oe, fe, ce;
    sfef_frame_check dut(.core_clk(core_clk), .rst(rst), .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso),
        .miso_oe(miso_oe), .extended_packet_select(ext), .packet_len(plen), .crc_check_en(cen),
        .other_warnings(ow), .flag_clear(flag_clear), .crc_bad(1'b0), .frame_error_flag(fe), .crc_error_flag(ce));
    sfef_ctrl_model m(.sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso));
    initial forever #20 core_clk = ~core_clk;
    function logic [20:0] fw(input int n, input logic b);
        r = {r[30:0], r[31] ^ r[21] ^ r[1] ^ r[0]};
        return (r[20:0] & ~(21'h1 << (n - 1))) | (21'(b) << (n - 1));
    endfunction
    task report_and_stop;
        $display("checked %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // Flags cleared first, so every case starts clean
    task run(input int l, e, n, b, s, input logic x);
        @(negedge core_clk);
        plen = 5'(l);
        ext = e[0];
        ow = r[8:0];
        cen = r[9];
        flag_clear = 1;
        @(negedge core_clk);
        flag_clear = 0;
        m.frame(n, fw(n, b[0]), s);
        m.frame(l, fw(l, 0), 0);
        q.push_back({1'b0, x, x & cen, 16'h0000});
        repeat (10) @(negedge core_clk);
        ->ev;
    endtask
    // Read request, then a NOP frame that carries the response back
    task rd(input logic [5:0] a, input logic lo);
        @(negedge core_clk);
        plen = 5'h10;
        ext = 0;
        ow = r[8:0];
        flag_clear = 1;
        @(negedge core_clk);
        flag_clear = 0;
        m.frame(16, {7'h00, a, 8'h00}, 0);
        m.frame(16, 21'h000000, 0);
        q.push_back({1'b1, 1'b0, 1'b0, lo ? {ow[7:0], 8'h00} : {4'hB, 3'h0, ow}});
        repeat (10) @(negedge core_clk);
        ->ev;
    endtask
    always @(ev)
    begin
        samples_checked++;
        if (fe !== q[0][17])
        begin
            $display("mismatch at %0t: %h vs %h", $time, fe, q[0][17]);
            miscompares++;
        end
        if (ce !== q[0][16])
        begin
            $display("mismatch at %0t: %h vs %h", $time, ce, q[0][16]);
            miscompares++;
        end
        if (q[0][18] && m.rx[15:0] !== q[0][15:0])
        begin
            $display("mismatch at %0t: %h vs %h", $time, m.rx[15:0], q[0][15:0]);
            miscompares++;
        end
        void'(q.pop_front());
    end
    initial
    begin
        #500000 miscompares++;
        report_and_stop;
    end
    initial
    begin
        repeat (2) @(negedge core_clk);
        rst = 0;
        repeat (2) @(negedge core_clk);
        run(16, 0, 16, 0, 0, 0);
        run(16, 0, 17, 0, 0, 1);
        run(16, 0, 16, 1, 0, 1);
        run(16, 0, 16, 0, 1, 1);
        run(16, 1, 16, 0, 2, 1);
        run(17, 1, 17, 0, 1, 1);
        run(21, 0, 21, 0, 3, 0);
        run(20, 0, 19, 0, 0, 1);
        rd(6'h26, 0);
        rd(6'h27, 1);
        report_and_stop;
    end
endmodule // spi_frame_error_flag_tb
`default_nettype wire
